// ---- src/dpm_pkg.sv ----
package dpm_pkg;
    localparam int ADDR_W = 14;
    localparam int DATA_W = 8;
    localparam logic [13:0] MBOX_LEFT_ADDR = 14'h3FFE;
    localparam logic [13:0] MBOX_RIGHT_ADDR = 14'h3FFF;
    localparam int FLAG_COUNT = 8;
    localparam int FLAG_ADDR_W = 3;
    // register offsets (byte addresses) of the controller's own registers
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_RDATA = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_CTRL = 8'h14;
    // command register fields
    localparam int CMD_GO_BIT = 0;
    localparam int CMD_WRITE_BIT = 1;
    localparam int CMD_FLAG_BIT = 2;
    localparam int CMD_PORT_BIT = 3;
    // control register fields
    localparam int CTRL_MASTER_BIT = 0;
    localparam int CTRL_WAIT_BIT = 1;
    // status register fields
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_DONE_BIT = 1;
    localparam int ST_COLL_BIT = 2;
    localparam int ST_LIRQ_BIT = 3;
    localparam int ST_RIRQ_BIT = 4;
    localparam int ST_LCOL_BIT = 5;
    localparam int ST_RCOL_BIT = 6;
    localparam int ST_INHIBIT_BIT = 7;
    // strobe timing: time at 10 MHz
    localparam int CLK_NS = 100;
    localparam int SETUP_NS = 100;
    localparam int STROBE_NS = 200;
    localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : dpm_pkg

// ---- src/dpm_port_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface dpm_port_if;
    import dpm_pkg::*;
    logic start;
    logic write;
    logic flag_space;
    logic [13:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic done;
    logic hit_collision;
    modport ctl (output start, write, flag_space, addr, wdata,
                 input rdata, done, hit_collision);
    modport seq (input start, write, flag_space, addr, wdata,
                 output rdata, done, hit_collision);
endinterface : dpm_port_if
`default_nettype wire

// ---- src/dpm_port_seq.sv ----
`timescale 1ns/1ps
`default_nettype none
// drives one port of the dual-port memory through one access
module dpm_port_seq
    import dpm_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    dpm_port_if.seq req,
    input wire logic wait_on_collision,
    input wire logic collision_n,
    output logic chip_sel_n,
    output logic flag_space_select_n,
    output logic rw_n,
    output logic out_en_n,
    output logic [13:0] addr,
    output logic [7:0] dq_out,
    output logic dq_oe,
    input wire logic [7:0] dq_in
);
    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_SETUP = 4'b0010,
        S_STROBE = 4'b0100,
        S_END = 4'b1000
    } dpm_seq_type;
    dpm_seq_type state_r;
    logic [3:0] cnt_r;
    logic coll_r;

    always_ff @(posedge clock) begin
        if (rst) begin
            state_r <= S_IDLE;
            cnt_r <= 4'h0;
            coll_r <= 1'b0;
        end else begin
            unique case (state_r)
                S_IDLE: begin
                    if (req.start) begin
                        state_r <= S_SETUP;
                        cnt_r <= 4'h0;
                        coll_r <= 1'b0;
                    end
                end
                // address and select settle before the strobe
                S_SETUP: begin
                    cnt_r <= cnt_r + 4'h1;
                    if (!collision_n && !req.flag_space)
                        coll_r <= 1'b1;
                    // a stalled port waits for the other side to finish
                    if (cnt_r >= 4'(SETUP_CYC - 1) &&
                        !(wait_on_collision && !collision_n &&
                          !req.flag_space)) begin
                        state_r <= S_STROBE;
                        cnt_r <= 4'h0;
                    end
                end
                S_STROBE: begin
                    cnt_r <= cnt_r + 4'h1;
                    if (!collision_n && !req.flag_space)
                        coll_r <= 1'b1;
                    if (cnt_r >= 4'(STROBE_CYC - 1))
                        state_r <= S_END;
                end
                S_END: state_r <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            chip_sel_n <= 1'b1;
            flag_space_select_n <= 1'b1;
            rw_n <= 1'b1;
            out_en_n <= 1'b1;
            addr <= 14'h0000;
            dq_out <= 8'hFF;
            dq_oe <= 1'b0;
        end else if (state_r == S_IDLE && req.start) begin
            // only one select low; both high leaves the port in standby
            chip_sel_n <= req.flag_space;
            flag_space_select_n <= !req.flag_space;
            addr <= req.addr;
            // flag writes use bit 0 only; zero requests, one releases
            dq_out <= req.wdata;
            dq_oe <= req.write;
        end else if (state_r == S_SETUP && state_r != S_IDLE &&
                     cnt_r >= 4'(SETUP_CYC - 1) &&
                     !(wait_on_collision && !collision_n &&
                       !req.flag_space)) begin
            rw_n <= !req.write;
            out_en_n <= req.write;
        end else if (state_r == S_STROBE &&
                     cnt_r >= 4'(STROBE_CYC - 1)) begin
            // strobe ends a cycle before select and data so the write lands
            rw_n <= 1'b1;
            out_en_n <= 1'b1;
        end else if (state_r == S_END) begin
            chip_sel_n <= 1'b1;
            flag_space_select_n <= 1'b1;
            rw_n <= 1'b1;
            out_en_n <= 1'b1;
            dq_oe <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            req.rdata <= 8'h00;
        end else if (state_r == S_STROBE && !req.write &&
                     cnt_r >= 4'(STROBE_CYC - 1)) begin
            req.rdata <= dq_in;
        end
    end

    assign req.done = (state_r == S_END);
    assign req.hit_collision = coll_r;

    a_strobe_after_setup: assert property (@(posedge clock) disable iff (rst)
        $fell(rw_n) |-> !chip_sel_n || !flag_space_select_n)
        else $error("write strobe without a select");
    a_standby_idle: assert property (@(posedge clock) disable iff (rst)
        state_r == S_IDLE && $past(state_r) == S_IDLE
        |-> chip_sel_n && flag_space_select_n)
        else $error("port not in standby when idle");
endmodule : dpm_port_seq
`default_nettype wire

// ---- src/dpm_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// How it works
// - slave: high collision input works, low blocks writes
// - hold address and select stable before starting the write
// - one master; slaves take its collision outputs as inhibits
// - depth expansion ANDs collision signals externally
// - write zero to request a flag, one to release; active low
module dpm_host
    import dpm_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic left_chip_sel_n,
    output logic left_flag_space_select_n,
    output logic left_rw_n,
    output logic left_out_en_n,
    output logic [13:0] left_addr,
    output logic [7:0] left_dq_out,
    output logic left_dq_oe,
    input wire logic [7:0] left_dq_in,
    input wire logic left_mailbox_irq_n,
    input wire logic left_collision_n,
    output logic right_chip_sel_n,
    output logic right_flag_space_select_n,
    output logic right_rw_n,
    output logic right_out_en_n,
    output logic [13:0] right_addr,
    output logic [7:0] right_dq_out,
    output logic right_dq_oe,
    input wire logic [7:0] right_dq_in,
    input wire logic right_mailbox_irq_n,
    input wire logic right_collision_n,
    output logic master_slave_sel
);
    dpm_port_if lp ();
    dpm_port_if rp ();

    logic [13:0] addr_r;
    logic [7:0] wdata_r;
    logic write_r, flag_r, port_r;
    logic master_r, wait_r;
    logic busy_r, done_r, coll_r;
    logic aw_held_r, w_held_r;
    logic [7:0] awaddr_r;
    logic [31:0] wword_r;
    logic [3:0] wstrb_r;
    logic [7:0] rdata_r;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] val,
                                          input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
            if (be[i])
                res[i*8 +: 8] = val[i*8 +: 8];
        return res;
    endfunction : merge

    // write channel: address and data taken independently
    assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
    assign s_axi_wready = !w_held_r && !s_axi_bvalid;

    always_ff @(posedge clock) begin
        if (rst) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= 8'h00;
            wword_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                wword_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (aw_held_r && w_held_r) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                unique case (awaddr_r)
                    REG_CMD, REG_ADDR, REG_WDATA, REG_CTRL:
                        s_axi_bresp <= RESP_OKAY;
                    default: s_axi_bresp <= RESP_SLVERR;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    logic wr_fire;
    logic [31:0] wr_cmd;
    assign wr_fire = aw_held_r && w_held_r;
    assign wr_cmd = merge(32'h0000_0000, wword_r, wstrb_r);

    always_ff @(posedge clock) begin
        if (rst) begin
            addr_r <= 14'h0000;
            wdata_r <= 8'hFF;
            master_r <= 1'b1;
            wait_r <= 1'b1;
        end else if (wr_fire) begin
            if (awaddr_r == REG_ADDR)
                addr_r <= wr_cmd[13:0];
            if (awaddr_r == REG_WDATA)
                wdata_r <= wr_cmd[7:0];
            if (awaddr_r == REG_CTRL) begin
                master_r <= wr_cmd[CTRL_MASTER_BIT];
                wait_r <= wr_cmd[CTRL_WAIT_BIT];
            end
        end
    end

    logic go;
    assign go = wr_fire && awaddr_r == REG_CMD && wr_cmd[CMD_GO_BIT] &&
                !busy_r;

    // a go while busy is dropped; one access at a time
    always_ff @(posedge clock) begin
        if (rst) begin
            write_r <= 1'b0;
            flag_r <= 1'b0;
            port_r <= 1'b0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            if (go) begin
                write_r <= wr_cmd[CMD_WRITE_BIT];
                flag_r <= wr_cmd[CMD_FLAG_BIT];
                port_r <= wr_cmd[CMD_PORT_BIT];
                busy_r <= 1'b1;
                done_r <= 1'b0;
            end else if (lp.done || rp.done) begin
                busy_r <= 1'b0;
                done_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            coll_r <= 1'b0;
            rdata_r <= 8'h00;
        end else if (lp.done) begin
            coll_r <= lp.hit_collision;
            rdata_r <= lp.rdata;
        end else if (rp.done) begin
            coll_r <= rp.hit_collision;
            rdata_r <= rp.rdata;
        end
    end

    // the mailbox message is plain data here
    assign lp.start = go && !wr_cmd[CMD_PORT_BIT];
    assign rp.start = go && wr_cmd[CMD_PORT_BIT];
    // the port samples the kind of access on the go edge itself
    logic cmd_write, cmd_flag;
    assign cmd_write = go ? wr_cmd[CMD_WRITE_BIT] : write_r;
    assign cmd_flag = go ? wr_cmd[CMD_FLAG_BIT] : flag_r;
    assign lp.write = cmd_write;
    assign rp.write = cmd_write;
    assign lp.flag_space = cmd_flag;
    assign rp.flag_space = cmd_flag;
    assign lp.addr = addr_r;
    assign rp.addr = addr_r;
    assign lp.wdata = wdata_r;
    assign rp.wdata = wdata_r;

    // holding the strobe off while collision is low keeps the write
    // several devices in depth share one ANDed collision input
    dpm_port_seq u_left (
        .clock(clock), .rst(rst), .req(lp),
        .wait_on_collision(wait_r), .collision_n(left_collision_n),
        .chip_sel_n(left_chip_sel_n),
        .flag_space_select_n(left_flag_space_select_n),
        .rw_n(left_rw_n), .out_en_n(left_out_en_n),
        .addr(left_addr), .dq_out(left_dq_out), .dq_oe(left_dq_oe),
        .dq_in(left_dq_in)
    );
    dpm_port_seq u_right (
        .clock(clock), .rst(rst), .req(rp),
        .wait_on_collision(wait_r), .collision_n(right_collision_n),
        .chip_sel_n(right_chip_sel_n),
        .flag_space_select_n(right_flag_space_select_n),
        .rw_n(right_rw_n), .out_en_n(right_out_en_n),
        .addr(right_addr), .dq_out(right_dq_out), .dq_oe(right_dq_oe),
        .dq_in(right_dq_in)
    );

    // one master only; collision pins feed our strobe wait logic and status bits
    assign master_slave_sel = master_r;

    // read channel
    logic [7:0] status;
    assign status = {1'b0, !right_collision_n, !left_collision_n,
                     !right_mailbox_irq_n, !left_mailbox_irq_n,
                     coll_r, done_r, busy_r};

    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge clock) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            unique case (s_axi_araddr)
                REG_ADDR: s_axi_rdata <= {18'h00000, addr_r};
                REG_WDATA: s_axi_rdata <= {24'h000000, wdata_r};
                REG_RDATA: s_axi_rdata <= {24'h000000, rdata_r};
                REG_STATUS: s_axi_rdata <= {24'h000000, status};
                REG_CTRL: s_axi_rdata <= {30'h00000000, wait_r, master_r};
                REG_CMD: s_axi_rdata <= 32'h0000_0000;
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    a_one_port_active: assert property (@(posedge clock) disable iff (rst)
        !(!left_chip_sel_n && !right_chip_sel_n))
        else $error("both ports driven by one controller access");
    a_busy_clears: assert property (@(posedge clock) disable iff (rst)
        go |=> busy_r ##[1:1000] !busy_r)
        else $error("access never completed");
    a_left_sel_go: assert property (@(posedge clock) disable iff (rst)
        go && !wr_cmd[CMD_PORT_BIT] && !wr_cmd[CMD_FLAG_BIT]
        |=> !left_chip_sel_n && left_flag_space_select_n)
        else $error("left chip select not asserted");
    a_flag_sel_go: assert property (@(posedge clock) disable iff (rst)
        go && wr_cmd[CMD_FLAG_BIT] && wr_cmd[CMD_PORT_BIT]
        |=> right_chip_sel_n && !right_flag_space_select_n)
        else $error("flag select not asserted");
    a_no_strobe_coll: assert property (@(posedge clock) disable iff (rst)
        wait_r && $fell(left_rw_n) |-> $past(left_collision_n) ||
        !left_flag_space_select_n)
        else $error("left write strobe during collision");
    a_right_no_strobe: assert property (@(posedge clock) disable iff (rst)
        wait_r && $fell(right_rw_n) |-> $past(right_collision_n) ||
        !right_flag_space_select_n)
        else $error("right write strobe during collision");
    a_left_write_end: assert property (@(posedge clock) disable iff (rst)
        $rose(left_rw_n) |-> left_dq_oe &&
        (!left_chip_sel_n || !left_flag_space_select_n))
        else $error("left write ended after its select or data");
    a_right_write_end: assert property (@(posedge clock) disable iff (rst)
        $rose(right_rw_n) |-> right_dq_oe &&
        (!right_chip_sel_n || !right_flag_space_select_n))
        else $error("right write ended after its select or data");
    a_right_sel_go: assert property (@(posedge clock) disable iff (rst)
        go && wr_cmd[CMD_PORT_BIT] && !wr_cmd[CMD_FLAG_BIT]
        |=> !right_chip_sel_n && right_flag_space_select_n)
        else $error("right chip select not asserted");
    a_left_flag_go: assert property (@(posedge clock) disable iff (rst)
        go && !wr_cmd[CMD_PORT_BIT] && wr_cmd[CMD_FLAG_BIT]
        |=> left_chip_sel_n && !left_flag_space_select_n)
        else $error("left flag select not asserted");
endmodule : dpm_host
`default_nettype wire

// ---- sim/dpm_dev_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// index 0 is the left port, index 1 the right port
module dpm_dev_model
    import dpm_pkg::*;
(
    input wire logic ms,
    input wire logic [1:0] cs_n,
    input wire logic [1:0] sem_n,
    input wire logic [1:0] rw_n,
    input wire logic [1:0] oe_n,
    input wire logic [1:0][13:0] addr,
    input wire logic [1:0][7:0] dq,
    input wire logic [1:0] ext_coll_n,
    output logic [1:0][7:0] rd,
    output logic [1:0] irq_n,
    output logic [1:0] coll_n
);
    logic [7:0] mem [0:16383];
    logic [1:0][7:0] req = '1;
    logic [1:0] own [0:7] = '{default: 2'd0};
    logic [1:0][7:0] last = '0;
    logic [1:0] busy;
    logic [1:0] inh;
    logic match;
    realtime t0 = 0;
    realtime t1 = 0;
    initial irq_n = 2'b11;
    always @(cs_n[0] or addr[0]) t0 = $realtime;
    always @(cs_n[1] or addr[1]) t1 = $realtime;
    assign match = !cs_n[0] && !cs_n[1] && addr[0] == addr[1];
    // the later arrival loses; a tie goes against the right port
    assign busy = {match && !(t0 > t1), match && t0 > t1};
    assign coll_n = ms ? ~busy : ext_coll_n;
    assign inh = ms ? busy : ~ext_coll_n;
    task automatic resolve(input logic [2:0] k, input int s);
        if (own[k] != 2'd0 && req[own[k] - 2'd1][k]) own[k] = 2'd0;
        if (own[k] == 2'd0)
            own[k] = !req[s][k] ? 2'(s + 1) : (!req[1 - s][k] ? 2'(2 - s) : 2'd0);
    endtask : resolve
    for (genvar s = 0; s < 2; s++) begin : g_side
        always @(posedge rw_n[s]) begin
            if (!cs_n[s] && !inh[s]) begin
                mem[addr[s]] = dq[s];
                if (addr[s] == (s ? MBOX_LEFT_ADDR : MBOX_RIGHT_ADDR))
                    irq_n[1 - s] = 1'b0;
            end
            if (cs_n[s] && !sem_n[s]) begin
                req[s][addr[s][2:0]] = dq[s][0];
                resolve(addr[s][2:0], s);
            end
        end
        always @(posedge oe_n[s])
            if (!cs_n[s] && !inh[s] &&
                addr[s] == (s ? MBOX_RIGHT_ADDR : MBOX_LEFT_ADDR))
                irq_n[s] = 1'b1;
        always @(negedge oe_n[s]) #1 last[s] = rd[s];
        always @* begin
            if (!oe_n[s] && !cs_n[s])
                rd[s] = mem[addr[s]];
            else if (!oe_n[s] && !sem_n[s])
                rd[s] = {8{own[addr[s][2:0]] != 2'(s + 1)}};
            else
                rd[s] = ~last[s];
        end
    end
endmodule : dpm_dev_model
`default_nettype wire

// ---- sim/dpm_host_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module dpm_host_tb_top import dpm_pkg::*;;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] s_axi_awaddr = '0;
    logic [7:0] s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, master_slave_sel, left_dq_oe, right_dq_oe;
    logic [1:0] s_axi_bresp, s_axi_rresp, irq_n, coll_n, resp;
    logic [31:0] s_axi_rdata, st;
    logic left_chip_sel_n, left_flag_space_select_n, left_rw_n;
    logic right_chip_sel_n, right_flag_space_select_n, right_rw_n;
    logic left_out_en_n, right_out_en_n;
    logic [13:0] left_addr, right_addr;
    logic [7:0] left_dq_out, right_dq_out, left_dq_in, right_dq_in;
    logic [1:0] ext_coll_n = 2'b11;
    logic [1:0][7:0] dev_rd;
    int n_errors = 0;
    int tests_run = 0;
    always #50 clock = ~clock;
    // each controller sees its own data while driving, else the device
    assign left_dq_in = left_dq_oe ? left_dq_out : dev_rd[0];
    assign right_dq_in = right_dq_oe ? right_dq_out : dev_rd[1];
    dpm_host uut (
        .clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .left_chip_sel_n,
        .left_flag_space_select_n, .left_rw_n, .left_out_en_n, .left_addr,
        .left_dq_out, .left_dq_oe, .left_dq_in,
        .left_mailbox_irq_n(irq_n[0]), .left_collision_n(coll_n[0]),
        .right_chip_sel_n, .right_flag_space_select_n, .right_rw_n,
        .right_out_en_n, .right_addr, .right_dq_out, .right_dq_oe,
        .right_dq_in, .right_mailbox_irq_n(irq_n[1]),
        .right_collision_n(coll_n[1]), .master_slave_sel
    );
    dpm_dev_model dev (
        .ms(master_slave_sel),
        .cs_n({right_chip_sel_n, left_chip_sel_n}),
        .sem_n({right_flag_space_select_n, left_flag_space_select_n}),
        .rw_n({right_rw_n, left_rw_n}),
        .oe_n({right_out_en_n, left_out_en_n}),
        .addr({right_addr, left_addr}),
        .dq({right_dq_oe ? right_dq_out : ~right_dq_out,
             left_dq_oe ? left_dq_out : ~left_dq_out}),
        .ext_coll_n, .rd(dev_rd), .irq_n, .coll_n
    );
    task automatic chk(input string n, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s exp %h seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while ((s_axi_awvalid && !s_axi_awready) ||
                   (s_axi_wvalid && !s_axi_wready));
        while (s_axi_bvalid !== 1'b1) @(posedge clock);
        s_axi_bready <= 1'b0;
        resp = s_axi_bresp;
    endtask : axw
    task automatic axr(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clock); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clock); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        resp = s_axi_rresp;
    endtask : axr
    task automatic start(input int p, input logic f, w,
                         input logic [13:0] a, input logic [7:0] wd);
        axw(REG_ADDR, {18'h0, a});
        axw(REG_WDATA, {24'h0, wd});
        axw(REG_CMD, {28'h0, p[0], f, w, 1'b1});
    endtask : start
    task automatic await_port(output logic [7:0] rd);
        logic [31:0] v;
        do axr(REG_STATUS, v); while (v[ST_BUSY_BIT] !== 1'b0);
        st = v;
        axr(REG_RDATA, v);
        rd = v[7:0];
    endtask : await_port
    task automatic acc(input int p, input logic f, w, input logic [13:0] a,
                       input logic [7:0] wd, output logic [7:0] rd);
        start(p, f, w, a, wd);
        await_port(rd);
    endtask : acc
    task automatic t_reset();
        logic [31:0] v;
        chk("ms pin", master_slave_sel, 1'b1);
        axr(REG_CTRL, v);
        chk("ctrl", v[1:0], 2'b11);
        axr(8'h40, v);
        chk("unmapped", {resp, v[29:0]}, {RESP_SLVERR, 30'h0});
        axw(8'h40, 32'h0);
        chk("wr unmapped", resp, RESP_SLVERR);
        chk("standby", {left_chip_sel_n, left_flag_space_select_n,
            right_chip_sel_n, right_flag_space_select_n, left_dq_oe,
            right_dq_oe}, 6'h3C);
    endtask : t_reset
    task automatic t_mailbox();
        logic [31:0] v;
        logic [7:0] d;
        logic [7:0] m;
        logic [13:0] a;
        int b;
        for (int p = 0; p < 2; p++) begin
            a = p ? MBOX_LEFT_ADDR : MBOX_RIGHT_ADDR;
            b = p ? ST_LIRQ_BIT : ST_RIRQ_BIT;
            m = 8'hA5 ^ 8'(p);
            acc(p, 1'b0, 1'b1, a, m, d);
            acc(p, 1'b0, 1'b0, a, 8'h00, d);
            axr(REG_STATUS, v);
            chk("irq set", {v[b], d}, {1'b1, m});
            acc(1 - p, 1'b0, 1'b0, a, 8'h00, d);
            axr(REG_STATUS, v);
            chk("irq clear", {v[b], d}, {1'b0, m});
        end
    endtask : t_mailbox
    task automatic t_flags();
        logic [7:0] d;
        acc(0, 1'b1, 1'b1, 14'd3, 8'h00, d);
        acc(1, 1'b1, 1'b1, 14'd3, 8'h00, d);
        acc(0, 1'b1, 1'b0, 14'd3, 8'h00, d);
        chk("left token", d, 8'h00);
        acc(1, 1'b1, 1'b0, 14'd3, 8'h00, d);
        chk("right refused", d, 8'hFF);
        acc(1, 1'b1, 1'b1, 14'd4, 8'h00, d);
        acc(1, 1'b1, 1'b0, 14'd4, 8'h00, d);
        chk("other flag", d, 8'h00);
        acc(0, 1'b1, 1'b1, 14'd3, 8'h01, d);
        acc(1, 1'b1, 1'b0, 14'd3, 8'h00, d);
        chk("token passed", d, 8'h00);
    endtask : t_flags
    task automatic t_slave();
        logic [31:0] v;
        logic [7:0] d;
        axw(REG_CTRL, 32'h0);
        chk("ctrl okay", resp, RESP_OKAY);
        chk("slave sel", master_slave_sel, 1'b0);
        acc(0, 1'b0, 1'b1, 14'h0100, 8'h11, d);
        chk("no coll", st[ST_COLL_BIT], 1'b0);
        @(posedge clock);
        ext_coll_n <= 2'b10;
        axr(REG_STATUS, v);
        chk("coll pins", v[ST_RCOL_BIT:ST_LCOL_BIT], 2'b01);
        acc(0, 1'b0, 1'b1, 14'h0100, 8'h22, d);
        chk("coll flag", st[ST_COLL_BIT], 1'b1);
        acc(0, 1'b0, 1'b1, MBOX_RIGHT_ADDR, 8'h77, d);
        axr(REG_STATUS, v);
        chk("no irq", v[ST_RIRQ_BIT], 1'b0);
        acc(1, 1'b0, 1'b1, 14'h0101, 8'h33, d);
        acc(1, 1'b0, 1'b0, 14'h0101, 8'h00, d);
        chk("free port", d, 8'h33);
        @(posedge clock);
        ext_coll_n <= 2'b11;
        acc(0, 1'b0, 1'b0, 14'h0100, 8'h00, d);
        chk("inhibited", d, 8'h11);
    endtask : t_slave
    task automatic t_wait();
        logic [31:0] v;
        logic [7:0] d;
        axw(REG_CTRL, 32'h2);
        @(posedge clock);
        ext_coll_n <= 2'b10;
        start(0, 1'b0, 1'b1, 14'h0102, 8'h44);
        // the controller must hold off its strobe while collision is low
        repeat (3) begin
            axr(REG_STATUS, v);
            chk("stalled", {v[ST_BUSY_BIT], left_rw_n}, 2'b11);
        end
        @(posedge clock);
        ext_coll_n <= 2'b11;
        await_port(d);
        acc(0, 1'b0, 1'b0, 14'h0102, 8'h00, d);
        chk("late write", d, 8'h44);
    endtask : t_wait
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize
    initial begin
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_mailbox();
        t_flags();
        t_slave();
        t_wait();
        summarize();
    end
    // the whole run needs well under a thousand cycles
    initial begin
        repeat (30000) @(posedge clock);
        n_errors++;
        summarize();
    end
endmodule : dpm_host_tb_top
`default_nettype wire
